// ===== verilog/ssf_status.sv
// ssf_status: status flags of one serial channel, apb register slave, interrupt
// assumes shift engines and dma controller on pclk, events one-cycle pulses
`timescale 1ns/1ps

module ssf_status (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        tx_load,
    input  wire logic        tx_last_bit,
    input  wire logic        rx_done,
    input  wire logic        rx_stop_bit,
    input  wire logic        rx_parity_fail,
    input  wire logic        rx_mp_bit,
    input  wire logic        dma_tx_write,
    input  wire logic        dma_rx_read,
    output logic             transmit_enable,
    output logic             receive_enable,
    output logic             transmit_multiproc_bit,
    output logic             transmit_empty_flag,
    output logic             receive_full_flag,
    output logic             irq
);
    typedef struct packed {
        logic [7:0]  status;
        logic [4:0]  seen_one;
        logic [1:0]  ctrl;
        logic [7:0]  irq_st;
        logic [7:0]  irq_msk;
        logic [31:0] rdata;
        logic        ready;
        logic        err;
        logic        irq;
    } ssf_state_s;

    ssf_state_s st_reg;
    ssf_state_s st_next;

    // ---------------------------------------------------------------
    // bus decode
    // ---------------------------------------------------------------
    logic access;
    logic wr;
    logic rd;
    logic mapped;
    assign access = psel && penable && !st_reg.ready;
    assign wr     = access && pwrite;
    assign rd     = access && !pwrite;
    assign mapped = (paddr == ssf_pkg::ADDR_STATUS) || (paddr == ssf_pkg::ADDR_CONTROL) ||
                    (paddr == ssf_pkg::ADDR_IRQ_ST) || (paddr == ssf_pkg::ADDR_IRQ_MSK);

    logic [4:0] set_ev;
    logic [4:0] clr_ev;
    logic [4:0] cur5;
    logic       tx_on;
    logic       rx_ok;
    logic       wr_st;

    always_comb begin
        st_next = st_reg;
        tx_on   = st_reg.ctrl[ssf_pkg::CBIT_TXEN];
        wr_st   = wr && (paddr == ssf_pkg::ADDR_STATUS);
        cur5    = st_reg.status[7:3];
        rx_ok   = rx_done && rx_stop_bit && !rx_parity_fail && !st_reg.status[ssf_pkg::BIT_RDF];
        // clearable flag order: tde, rdf, ovr, frm, par
        set_ev[4] = !tx_on || tx_load;
        set_ev[3] = rx_ok;
        set_ev[2] = rx_done && st_reg.status[ssf_pkg::BIT_RDF];
        set_ev[1] = rx_done && !rx_stop_bit;
        set_ev[0] = rx_done && rx_parity_fail;
        // a zero clears only a flag previously read as one; ones are ignored
        clr_ev = {5{wr_st}} & ~pwdata[7:3] & st_reg.seen_one;
        clr_ev[4] = clr_ev[4] || dma_tx_write;
        clr_ev[3] = clr_ev[3] || dma_rx_read;
        // receive enable is never looked at here, so rx full keeps its value
        st_next.status[7:3] = (cur5 & ~clr_ev) | set_ev;
        // tx end shares the clear of tx empty, set wins
        if (!tx_on || (tx_last_bit && st_reg.status[ssf_pkg::BIT_TDE])) begin
            st_next.status[ssf_pkg::BIT_TXEND] = 1'b1;
        end else if (clr_ev[4]) begin
            st_next.status[ssf_pkg::BIT_TXEND] = 1'b0;
        end
        if (rx_done && st_reg.ctrl[ssf_pkg::CBIT_RXEN]) begin
            st_next.status[ssf_pkg::BIT_MPR] = rx_mp_bit;
        end
        if (wr_st) begin
            st_next.status[ssf_pkg::BIT_MPT] = pwdata[ssf_pkg::BIT_MPT];
        end
        // arm a clear only after a read that returned one; a clear disarms
        st_next.seen_one = st_reg.seen_one & ~clr_ev;
        if (rd && paddr == ssf_pkg::ADDR_STATUS) begin
            st_next.seen_one = st_reg.seen_one | cur5;
        end
        if (wr && paddr == ssf_pkg::ADDR_CONTROL) begin
            st_next.ctrl = pwdata[1:0];
        end
        if (wr && paddr == ssf_pkg::ADDR_IRQ_MSK) begin
            st_next.irq_msk = pwdata[7:0];
        end
        // interrupt status: rising flags set, read clears, set wins
        if (rd && paddr == ssf_pkg::ADDR_IRQ_ST) begin
            st_next.irq_st = 8'h00;
        end
        st_next.irq_st[7:3] = st_next.irq_st[7:3] | (set_ev & ~cur5);
        st_next.ready = access;
        st_next.err   = access && !mapped;
        st_next.rdata = 32'h0000_0000;
        if (rd) begin
            case (paddr)
                ssf_pkg::ADDR_STATUS:  st_next.rdata = {24'h00_0000, st_reg.status};
                ssf_pkg::ADDR_CONTROL: st_next.rdata = {30'h0000_0000, st_reg.ctrl};
                ssf_pkg::ADDR_IRQ_ST:  st_next.rdata = {24'h00_0000, st_reg.irq_st};
                ssf_pkg::ADDR_IRQ_MSK: st_next.rdata = {24'h00_0000, st_reg.irq_msk};
                default:               st_next.rdata = 32'h0000_0000;
            endcase
        end
        st_next.irq = |(st_next.irq_st & st_next.irq_msk);
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg        <= '0;
            st_reg.status <= ssf_pkg::STATUS_RST;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    assign prdata                 = st_reg.rdata;
    assign pready                 = st_reg.ready;
    assign pslverr                = st_reg.err;
    assign irq                    = st_reg.irq;
    assign transmit_enable        = st_reg.ctrl[ssf_pkg::CBIT_TXEN];
    assign receive_enable         = st_reg.ctrl[ssf_pkg::CBIT_RXEN];
    assign transmit_multiproc_bit = st_reg.status[ssf_pkg::BIT_MPT];
    assign transmit_empty_flag    = st_reg.status[ssf_pkg::BIT_TDE];
    assign receive_full_flag      = st_reg.status[ssf_pkg::BIT_RDF];

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    // every flag and control check is gated by clk_en (the bus and irq checks are not): while it is low no flag may move
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // dma clears per clearable flag, same order as set_ev and clr_ev
    logic [4:0] dma_clr;
    assign dma_clr = {dma_tx_write, dma_rx_read, 3'b000};

    // ---------------------------------------------------------------
    // transmit empty
    // ---------------------------------------------------------------
    chk_txe_off_set: assert property (
        clk_en && !transmit_enable |=> transmit_empty_flag)
        else $error("tx empty not set while tx off");

    chk_txe_load_set: assert property (
        clk_en && tx_load |=> transmit_empty_flag)
        else $error("tx empty not set on load");

    chk_txe_sw_clear: assert property (
        clk_en && transmit_enable && !tx_load && wr_st && !pwdata[7]
        && st_reg.seen_one[4] |=> !transmit_empty_flag)
        else $error("armed zero write did not clear tx empty");

    chk_txe_unarmed: assert property (
        clk_en && wr_st && !st_reg.seen_one[4] && !dma_tx_write
        && transmit_empty_flag |=> transmit_empty_flag)
        else $error("tx empty cleared without read");

    chk_dma_clr_txe: assert property (
        clk_en && transmit_enable && dma_tx_write && !tx_load
        |=> !transmit_empty_flag)
        else $error("dma write did not clear tx empty");

    // ---------------------------------------------------------------
    // receive full
    // ---------------------------------------------------------------
    chk_rdf_set: assert property (
        clk_en && rx_ok |=> receive_full_flag)
        else $error("rx full not set");

    chk_rdf_sw_clear: assert property (
        clk_en && wr_st && !pwdata[6] && st_reg.seen_one[3] && !rx_done
        |=> !receive_full_flag)
        else $error("armed zero write did not clear rx full");

    chk_dma_clr_rdf: assert property (
        clk_en && dma_rx_read && !rx_done
        |=> !receive_full_flag)
        else $error("dma read did not clear rx full");

    chk_rdf_rxoff_hold: assert property (
        clk_en && !receive_enable && !rx_done && !dma_rx_read && !wr_st
        |=> receive_full_flag == $past(receive_full_flag))
        else $error("rx full moved while rx off");

    // ---------------------------------------------------------------
    // error flags
    // ---------------------------------------------------------------
    chk_ovr_set: assert property (
        clk_en && rx_done && receive_full_flag
        |=> st_reg.status[ssf_pkg::BIT_OVR])
        else $error("overrun not set");

    chk_unarmed_hold: assert property (
        clk_en && wr_st && !st_reg.seen_one[2] && !rx_done
        && st_reg.status[ssf_pkg::BIT_OVR] |=> st_reg.status[ssf_pkg::BIT_OVR])
        else $error("overrun cleared without read");

    chk_ovr_sw_clear: assert property (
        clk_en && wr_st && !pwdata[5] && st_reg.seen_one[2] && !rx_done
        |=> !st_reg.status[ssf_pkg::BIT_OVR])
        else $error("armed zero write did not clear overrun");

    chk_frm_set: assert property (
        clk_en && rx_done && !rx_stop_bit
        |=> st_reg.status[ssf_pkg::BIT_FRM])
        else $error("framing not set");

    chk_frm_sw_clear: assert property (
        clk_en && wr_st && !pwdata[4] && st_reg.seen_one[1] && !rx_done
        |=> !st_reg.status[ssf_pkg::BIT_FRM])
        else $error("armed zero write did not clear framing");

    chk_par_set: assert property (
        clk_en && rx_done && rx_parity_fail
        |=> st_reg.status[ssf_pkg::BIT_PAR])
        else $error("parity not set");

    chk_par_sw_clear: assert property (
        clk_en && wr_st && !pwdata[3] && st_reg.seen_one[0] && !rx_done
        |=> !st_reg.status[ssf_pkg::BIT_PAR])
        else $error("armed zero write did not clear parity");

    // ---------------------------------------------------------------
    // transmit end
    // ---------------------------------------------------------------
    chk_txend_off: assert property (
        clk_en && !transmit_enable
        |=> st_reg.status[ssf_pkg::BIT_TXEND])
        else $error("tx end not set while tx off");

    chk_txend_last: assert property (
        clk_en && tx_last_bit && transmit_empty_flag
        |=> st_reg.status[ssf_pkg::BIT_TXEND])
        else $error("tx end not set on last bit");

    chk_txend_dma_clr: assert property (
        clk_en && transmit_enable && dma_tx_write && !tx_last_bit
        |=> !st_reg.status[ssf_pkg::BIT_TXEND])
        else $error("tx end not cleared with tx empty");

    // ---------------------------------------------------------------
    // multiprocessor bits
    // ---------------------------------------------------------------
    chk_mpr_capture: assert property (
        clk_en && rx_done && receive_enable
        |=> st_reg.status[ssf_pkg::BIT_MPR] == $past(rx_mp_bit))
        else $error("rx multiproc bit not captured");

    chk_mpr_hold: assert property (
        clk_en && !receive_enable
        |=> st_reg.status[ssf_pkg::BIT_MPR] == $past(st_reg.status[ssf_pkg::BIT_MPR]))
        else $error("rx multiproc bit moved while rx off");

    chk_mpt_wr: assert property (
        clk_en && wr_st
        |=> transmit_multiproc_bit == $past(pwdata[0]))
        else $error("tx multiproc bit not written");

    // ---------------------------------------------------------------
    // per clearable flag: ones ignored, set beats clear
    // ---------------------------------------------------------------
    // a one written over a set flag must never clear it, and a set in
    // the same cycle as an armed clear must win so no event is lost
    for (genvar i = 0; i < 5; i++) begin : g_flag
        chk_ones_kept: assert property (
            clk_en && wr_st && pwdata[3 + i] && !dma_clr[i]
            && st_reg.status[3 + i] |=> st_reg.status[3 + i])
            else $error("write of one cleared a flag");

        chk_set_wins: assert property (
            clk_en && set_ev[i] && wr_st && !pwdata[3 + i]
            |=> st_reg.status[3 + i])
            else $error("clear beat a hardware set");
    end

    // ---------------------------------------------------------------
    // bus, control and interrupt
    // ---------------------------------------------------------------
    chk_pready_pulse: assert property (
        pready |=> !pready)
        else $error("pready held for more than one cycle");

    chk_err_with_ready: assert property (
        pslverr |-> pready)
        else $error("pslverr without pready");

    chk_rdata_idle: assert property (
        !pready |-> prdata == 32'h0000_0000)
        else $error("read data outside a response");

    chk_ctrl_wr: assert property (
        clk_en && wr && paddr == ssf_pkg::ADDR_CONTROL
        |=> {receive_enable, transmit_enable} == $past(pwdata[1:0]))
        else $error("control write lost");

    chk_freeze_hold: assert property (
        !clk_en |=> $stable(st_reg))
        else $error("state moved while clock enable low");

    chk_irq_level: assert property (
        irq == |(st_reg.irq_st & st_reg.irq_msk))
        else $error("irq mismatch");

    // ---------------------------------------------------------------
    // scenarios worth seeing
    // ---------------------------------------------------------------
    cov_overrun:    cover property (rx_done && receive_full_flag);
    cov_sw_clear:   cover property (wr_st && |clr_ev);
    cov_irq:        cover property (irq);
    cov_set_clear:  cover property (|(set_ev & clr_ev));
    cov_txend_last: cover property (tx_last_bit && transmit_empty_flag);
endmodule : ssf_status

// ===== verilog/ssf_pkg.sv
// ssf_pkg: register map, bit positions and reset values of the serial status flag block
// assumes a 32-bit apb slave with word-aligned registers
package ssf_pkg;
    localparam logic [11:0] ADDR_STATUS  = 12'h000;
    localparam logic [11:0] ADDR_CONTROL = 12'h004;
    localparam logic [11:0] ADDR_IRQ_ST  = 12'h008;
    localparam logic [11:0] ADDR_IRQ_MSK = 12'h00C;

    localparam int BIT_TDE  = 7;
    localparam int BIT_RDF  = 6;
    localparam int BIT_OVR  = 5;
    localparam int BIT_FRM  = 4;
    localparam int BIT_PAR  = 3;
    localparam int BIT_TXEND = 2;
    localparam int BIT_MPR  = 1;
    localparam int BIT_MPT  = 0;

    localparam int CBIT_TXEN = 0;
    localparam int CBIT_RXEN = 1;

    localparam logic [7:0] STATUS_RST = 8'h84;
    localparam logic [4:0] CLR_MASK   = 5'h1F;
endpackage : ssf_pkg

// ===== tb/ssf_peer_model.sv
// ssf_peer_model: line-side peer and shift engines seen by the status flag block
// assumes the block takes each pulse at the next pclk edge
`timescale 1ns/1ps
module ssf_peer_model (
    pclk,
    transmit_enable,
    transmit_empty_flag,
    tx_load,
    tx_last_bit,
    rx_done,
    rx_stop_bit,
    rx_parity_fail,
    rx_mp_bit
);
    input  wire logic pclk;
    input  wire logic transmit_enable;
    input  wire logic transmit_empty_flag;
    output logic      tx_load;
    output logic      tx_last_bit;
    output logic      rx_done;
    output logic      rx_stop_bit;
    output logic      rx_parity_fail;
    output logic      rx_mp_bit;
    logic [3:0]       bits_left;
    initial {tx_load, tx_last_bit, rx_done, rx_stop_bit, rx_parity_fail, rx_mp_bit} = '0;
    initial bits_left = 4'h0;
    // takes a word as soon as the holder fills; a character lasts ten bits
    always @(posedge pclk) begin
        tx_load     <= 1'b0;
        tx_last_bit <= (bits_left == 4'h1);
        if (bits_left != 4'h0) begin
            bits_left <= bits_left - 4'h1;
        end else if (transmit_enable && !transmit_empty_flag) begin
            tx_load   <= 1'b1;
            bits_left <= 4'hA;
        end
    end
    // frame fields go stale (inverted) once the done pulse is over
    task automatic frame(input logic stop, input logic par, input logic mp);
        @(posedge pclk);
        {rx_done, rx_stop_bit, rx_parity_fail, rx_mp_bit} <= {1'b1, stop, par, mp};
        @(posedge pclk);
        {rx_done, rx_stop_bit, rx_parity_fail, rx_mp_bit} <= {1'b0, ~stop, ~par, ~mp};
    endtask : frame
endmodule : ssf_peer_model

// ===== tb/serial_status_flags_tb_top.sv
// serial_status_flags_tb_top: directed apb bench of the status flag block
// assumes the ssf_pkg register map and a peer model on the line side
`timescale 1ns/1ps
module serial_status_flags_tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic        tx_load, tx_last_bit, rx_done, rx_stop_bit, rx_parity_fail, rx_mp_bit;
    logic        dma_tx_write, dma_rx_read, transmit_enable, transmit_multiproc_bit;
    logic        clk_en, receive_enable;
    logic        transmit_empty_flag, receive_full_flag;
    int          mismatches, num_checks;
    ssf_status dut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .tx_load, .tx_last_bit, .rx_done, .rx_stop_bit,
        .rx_parity_fail, .rx_mp_bit, .dma_tx_write, .dma_rx_read, .transmit_enable,
        .receive_enable, .transmit_multiproc_bit, .transmit_empty_flag,
        .receive_full_flag, .irq);
    ssf_peer_model peer (.pclk, .transmit_enable, .transmit_empty_flag, .tx_load,
        .tx_last_bit, .rx_done, .rx_stop_bit, .rx_parity_fail, .rx_mp_bit);
    always #12.5 pclk = ~pclk;
    // ----------------------------------------
    // bus and compare tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t exp %h got %h", $time, exp, got);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q   = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(e, q);
    endtask : rd
    task automatic results;
        if (mismatches == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata, dma_tx_write, dma_rx_read} = '0;
        clk_en = 1'b1;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(ssf_pkg::ADDR_STATUS, 32'h0000_0084);
        apb(1'b1, ssf_pkg::ADDR_CONTROL, 32'h0000_0003);
        chk(32'h0000_0003, {30'h0, receive_enable, transmit_enable});
        apb(1'b1, ssf_pkg::ADDR_STATUS, 32'h0000_00FF);
        chk(32'h0000_0001, {31'h0, transmit_multiproc_bit});
        apb(1'b1, ssf_pkg::ADDR_STATUS, 32'h0000_0001);
        #1 chk(32'h0000_0000, {31'h0, transmit_empty_flag});
        repeat (16) @(posedge pclk);
        apb(1'b1, ssf_pkg::ADDR_STATUS, 32'h0000_0001);
        #1 chk(32'h0000_0001, {31'h0, transmit_empty_flag});
        rd(ssf_pkg::ADDR_STATUS, 32'h0000_0085);
        @(posedge pclk) dma_tx_write <= 1'b1;
        @(posedge pclk) dma_tx_write <= 1'b0;
        #1 chk(32'h0000_0000, {31'h0, transmit_empty_flag});
        repeat (16) @(posedge pclk);
        apb(1'b1, ssf_pkg::ADDR_IRQ_MSK, 32'h0000_0040);
        apb(1'b0, ssf_pkg::ADDR_IRQ_ST, 32'h0000_0000);
        peer.frame(1'b1, 1'b0, 1'b1);
        repeat (3) @(posedge pclk);
        chk(32'h0000_0003, {30'h0, irq, receive_full_flag});
        rd(ssf_pkg::ADDR_IRQ_ST, 32'h0000_0040);
        repeat (2) @(posedge pclk);
        chk(32'h0000_0000, {31'h0, irq});
        peer.frame(1'b1, 1'b0, 1'b0);
        peer.frame(1'b0, 1'b1, 1'b0);
        rd(ssf_pkg::ADDR_STATUS, 32'h0000_00FD);
        apb(1'b1, ssf_pkg::ADDR_STATUS, 32'h0000_0081);
        rd(ssf_pkg::ADDR_STATUS, 32'h0000_0085);
        peer.frame(1'b1, 1'b0, 1'b1);
        apb(1'b1, ssf_pkg::ADDR_CONTROL, 32'h0000_0001);
        chk(32'h0000_0001, {30'h0, receive_enable, transmit_enable});
        rd(ssf_pkg::ADDR_STATUS, 32'h0000_00C7);
        peer.frame(1'b1, 1'b0, 1'b0);
        rd(ssf_pkg::ADDR_STATUS, 32'h0000_00E7);
        @(posedge pclk) dma_rx_read <= 1'b1;
        @(posedge pclk) dma_rx_read <= 1'b0;
        #1 chk(32'h0000_0000, {31'h0, receive_full_flag});
        @(posedge pclk) clk_en <= 1'b0;
        peer.frame(1'b1, 1'b0, 1'b0);
        @(posedge pclk) clk_en <= 1'b1;
        #1 chk(32'h0000_0000, {31'h0, receive_full_flag});
        rd(12'h010, 32'h0000_0000);
        chk(32'h0000_0001, {31'h0, err});
        results();
    end
    initial begin
        repeat (2000) @(posedge pclk);
        mismatches++;
        results();
    end
endmodule : serial_status_flags_tb_top
